// >>> hdl/phy_link_power_saver.sv
// phy_link_power_saver: per port automatic low power state machine
// assumes energy_detect and link_up come from pins or the analog
// front end (synchronised here) and a classic wishbone master
`timescale 1ns/10ps

// Function
// - saver mode enabled per port anytime
// - exactly three states: low, wake, normal
// - alternate low and wake until energy
// - energy detected moves to normal state
// - autoneg link drop: time-out then low
// - reset enters low power state
// - forced speed: stay normal after drop
// - autoneg turned off in normal: stay
// - low power: blocks off, monitor energy
// - sleep period from sleep timer field
// - sleep randomized minus 80 plus 60 ms
// - wake sends three bursts, pairs alternate
// - after wake without energy, back to low
// - link time-out from two saver bits
// - manual power-down bit kept separately
// - autoneg enable from control bit 12
module phy_link_power_saver
  import power_saver_pkg::*;
#(
  parameter int sleep_ms_0   = 1000,
  parameter int sleep_ms_1   = 2000,
  parameter int sleep_ms_2   = 3000,
  parameter int sleep_ms_3   = 4000,
  parameter int wake_ms_0    = 160,
  parameter int wake_ms_1    = 400,
  parameter int wake_ms_2    = 800,
  parameter int wake_ms_3    = 1600,
  parameter int linkto_ms_0  = 1000,
  parameter int linkto_ms_1  = 2000,
  parameter int linkto_ms_2  = 3000,
  parameter int linkto_ms_3  = 4000,
  parameter int ms_cycles    = cycles_per_ms
)(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         energy_detect,
  input  wire logic         link_up,
  output logic              blocks_on,
  output logic              burst_active,
  output logic              burst_pair_b,
  output logic              manual_power_down,
  output logic              low_power_flag
);
  import power_saver_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] energy_sync;
  logic [1:0] link_sync;
  always_ff @(posedge clk) begin
    if (srst) begin
      energy_sync <= 2'h0;
      link_sync   <= 2'h0;
    end else begin
      energy_sync <= {energy_sync[0], energy_detect};
      link_sync   <= {link_sync[0], link_up};
    end
  end
  logic energy;
  logic link;
  assign energy = energy_sync[1];
  assign link   = link_sync[1];

  // ---------------------------------------------------------------
  // registers and wishbone slave
  // ---------------------------------------------------------------
  logic [15:0]  control_reg;
  logic [15:0]  saver_reg;
  logic [15:0]  timer_reg;
  logic [15:0]  next_control_reg;
  logic [15:0]  next_saver_reg;
  logic [15:0]  next_timer_reg;
  logic [31:0]  next_wb_dat_o;
  logic         next_wb_ack_o;
  logic         access;
  saver_state_e state;
  saver_state_e next_state;
  saver_cfg_s   cfg;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : merge

  always_comb begin
    next_control_reg = control_reg;
    next_saver_reg   = saver_reg;
    next_timer_reg   = timer_reg;
    next_wb_ack_o    = access;
    next_wb_dat_o    = 32'h0000_0000;
    // writes land on the ack edge, while the master still holds the request
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      unique case (wb_adr_i)
        control_addr: next_control_reg = merge(control_reg, wb_dat_i, wb_sel_i);
        saver_addr:   next_saver_reg   = merge(saver_reg, wb_dat_i, wb_sel_i);
        timer_addr:   next_timer_reg   = merge(timer_reg, wb_dat_i, wb_sel_i);
        default:      next_wb_dat_o    = 32'h0000_0000;
      endcase
    end
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        control_addr: next_wb_dat_o = {16'h0000, control_reg};
        saver_addr:   next_wb_dat_o = {16'h0000, saver_reg};
        timer_addr:   next_wb_dat_o = {16'h0000, timer_reg};
        status_addr:  next_wb_dat_o = {27'h0000000, link, energy, state};
        default:      next_wb_dat_o = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      control_reg <= control_reset;
      saver_reg   <= saver_reset;
      timer_reg   <= timer_reset;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      control_reg <= next_control_reg;
      saver_reg   <= next_saver_reg;
      timer_reg   <= next_timer_reg;
      wb_ack_o    <= next_wb_ack_o;
      wb_dat_o    <= next_wb_dat_o;
    end
  end

  always_comb begin
    cfg.power_down       = control_reg[power_down_bit];
    cfg.autoneg          = control_reg[autoneg_bit];
    cfg.saver_en         = saver_reg[saver_en_bit];
    cfg.link_timeout_sel = {saver_reg[linkto_hi_bit], saver_reg[linkto_lo_bit]};
    cfg.sleep_sel        = timer_reg[sleep_lsb +: 2];
    cfg.wake_sel         = timer_reg[wake_lsb +: 2];
  end

  // ---------------------------------------------------------------
  // millisecond tick and duration maps
  // ---------------------------------------------------------------
  logic [31:0] ms_cnt;
  logic [31:0] next_ms_cnt;
  logic        ms_tick;
  assign ms_tick = (ms_cnt == 32'(ms_cycles - 1));
  always_comb begin
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ms_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= next_ms_cnt;
    end
  end

  logic [15:0] sleep_ms;
  logic [15:0] wake_ms;
  logic [15:0] linkto_ms;
  always_comb begin
    unique case (cfg.sleep_sel)
      2'h0: sleep_ms = 16'(sleep_ms_0);
      2'h1: sleep_ms = 16'(sleep_ms_1);
      2'h2: sleep_ms = 16'(sleep_ms_2);
      2'h3: sleep_ms = 16'(sleep_ms_3);
    endcase
    unique case (cfg.wake_sel)
      2'h0: wake_ms = 16'(wake_ms_0);
      2'h1: wake_ms = 16'(wake_ms_1);
      2'h2: wake_ms = 16'(wake_ms_2);
      2'h3: wake_ms = 16'(wake_ms_3);
    endcase
    unique case (cfg.link_timeout_sel)
      2'h0: linkto_ms = 16'(linkto_ms_0);
      2'h1: linkto_ms = 16'(linkto_ms_1);
      2'h2: linkto_ms = 16'(linkto_ms_2);
      2'h3: linkto_ms = 16'(linkto_ms_3);
    endcase
  end

  logic [7:0] rand_ms;
  random_window u_rand (
    .clk       (clk),
    .srst      (srst),
    .offset_ms (rand_ms)
  );

  logic [15:0] sleep_target;
  always_comb begin
    if (sleep_ms > 16'(jitter_low_ms)) begin
      sleep_target = sleep_ms - 16'(jitter_low_ms) + {8'h00, rand_ms};
    end else begin
      sleep_target = 16'h0001 + {8'h00, rand_ms};
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  logic [15:0] dwell;
  logic [15:0] next_dwell;
  logic [15:0] target;
  logic [15:0] next_target;
  logic        stay_up;
  logic        next_stay_up;
  logic        seen_link;
  logic        next_seen_link;
  logic [1:0]  bursts;
  logic [1:0]  next_bursts;
  logic [15:0] burst_len;
  saver_ctl_s  ctl;

  // a zero burst length is clamped to one ms; either ends at the first ms tick
  always_comb begin
    burst_len = wake_ms / 16'(burst_count);
    if (burst_len == 16'h0000) begin
      burst_len = 16'h0001;
    end
  end

  always_comb begin
    next_state     = state;
    next_dwell     = ms_tick ? dwell + 16'h0001 : dwell;
    next_target    = target;
    next_stay_up   = stay_up;
    next_seen_link = seen_link;
    next_bursts    = bursts;
    unique case (state)
      st_low_power: begin
        if (!cfg.saver_en || energy) begin
          next_state     = st_normal;
          next_dwell     = 16'h0000;
          next_stay_up   = !cfg.autoneg;
          next_seen_link = 1'b0;
        end else if (ms_tick && next_dwell >= target) begin
          next_state  = st_wake;
          next_dwell  = 16'h0000;
          next_bursts = 2'h0;
        end
      end
      st_wake: begin
        if (energy) begin
          next_state     = st_normal;
          next_dwell     = 16'h0000;
          next_stay_up   = !cfg.autoneg;
          next_seen_link = 1'b0;
        end else if (ms_tick && next_dwell >= burst_len) begin
          next_dwell  = 16'h0000;
          next_bursts = bursts + 2'h1;
          if (bursts == 2'(burst_count - 1)) begin
            next_state  = st_low_power;
            next_target = sleep_target;
          end
        end
      end
      st_normal: begin
        if (!cfg.autoneg) begin
          next_stay_up = 1'b1;
        end
        if (link) begin
          next_seen_link = 1'b1;
          next_dwell     = 16'h0000;
        end
        if (link || !cfg.saver_en || stay_up) begin
          next_dwell = 16'h0000;
        end else if (ms_tick && next_dwell >= linkto_ms) begin
          next_state  = st_low_power;
          next_dwell  = 16'h0000;
          next_target = sleep_target;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= st_low_power;
      dwell     <= 16'h0000;
      target    <= 16'(sleep_ms_1);
      stay_up   <= 1'b0;
      seen_link <= 1'b0;
      bursts    <= 2'h0;
    end else begin
      state     <= next_state;
      dwell     <= next_dwell;
      target    <= next_target;
      stay_up   <= next_stay_up;
      seen_link <= next_seen_link;
      bursts    <= next_bursts;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    ctl.blocks_on    = (next_state == st_normal) && !cfg.power_down;
    ctl.burst_active = (next_state == st_wake);
    ctl.burst_pair_b = next_bursts[0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      blocks_on         <= 1'b0;
      burst_active      <= 1'b0;
      burst_pair_b      <= 1'b0;
      manual_power_down <= 1'b0;
      low_power_flag    <= 1'b1;
    end else begin
      blocks_on         <= ctl.blocks_on;
      burst_active      <= ctl.burst_active;
      burst_pair_b      <= ctl.burst_pair_b;
      manual_power_down <= cfg.power_down;
      low_power_flag    <= (next_state == st_low_power);
    end
  end

endmodule : phy_link_power_saver

// >>> hdl/power_saver_pkg.sv
// power saver package: register map, field layout, timing constants
// assumes a 200 MHz system clock and a classic wishbone slave port
package power_saver_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] control_addr   = 8'h00;
  localparam logic [7:0] saver_addr     = 8'h04;
  localparam logic [7:0] timer_addr     = 8'h08;
  localparam logic [7:0] status_addr    = 8'h0C;

  // control register: standard basic control word
  localparam int power_down_bit  = 11;
  localparam int autoneg_bit     = 12;
  // saver register: mode bits
  localparam int saver_en_bit    = 6;
  localparam int linkto_hi_bit   = 7;
  localparam int linkto_lo_bit   = 2;
  // timer register: field positions
  localparam int sleep_lsb       = 13;
  localparam int wake_lsb        = 11;

  localparam logic [15:0] control_reset = 16'h1000;
  localparam logic [15:0] saver_reset   = 16'h0000;
  localparam logic [15:0] timer_reset   = 16'h2000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int clk_mhz         = 200;
  localparam int cycles_per_ms   = clk_mhz * 1000;
  localparam int jitter_low_ms   = 80;
  localparam int jitter_high_ms  = 60;
  localparam int jitter_span_ms  = jitter_low_ms + jitter_high_ms;
  localparam int burst_count     = 3;

  // ---------------------------------------------------------------
  // states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_low_power = 3'b001,
    st_wake      = 3'b010,
    st_normal    = 3'b100
  } saver_state_e;

  typedef struct packed {
    logic       power_down;
    logic       autoneg;
    logic       saver_en;
    logic [1:0] link_timeout_sel;
    logic [1:0] sleep_sel;
    logic [1:0] wake_sel;
  } saver_cfg_s;

  typedef struct packed {
    logic       blocks_on;
    logic       burst_active;
    logic       burst_pair_b;
  } saver_ctl_s;

endpackage : power_saver_pkg

// >>> hdl/random_window.sv
// random_window: free running lfsr giving a jitter offset in ms
// assumes one clock; the consumer samples value when it needs it
`timescale 1ns/10ps
module random_window
  import power_saver_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  output logic [7:0]      offset_ms
);

  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic [7:0]  next_offset_ms;

  // ---------------------------------------------------------------
  // lfsr and reduction into the jitter span
  // ---------------------------------------------------------------
  always_comb begin
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    if (lfsr[7:0] > 8'(jitter_span_ms)) begin
      next_offset_ms = lfsr[7:0] - 8'(jitter_span_ms) - 8'h01;
    end else begin
      next_offset_ms = lfsr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr      <= 16'hACE1;
      offset_ms <= 8'h00;
    end else begin
      lfsr      <= next_lfsr;
      offset_ms <= next_offset_ms;
    end
  end

endmodule : random_window

// >>> sim/power_saver_sva.sv
// checker: bus, state and timing relations at the saver ports
// assumes binding into phy_link_power_saver with the sim timing params
`timescale 1ns/10ps
module power_saver_sva
  import power_saver_pkg::*;
#(
  parameter int ms_cycles  = cycles_per_ms,
  parameter int wake_ms_3  = 1600,
  parameter int sleep_ms_3 = 4000
)(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        energy_detect,
  input wire logic        blocks_on,
  input wire logic        burst_active,
  input wire logic        manual_power_down,
  input wire logic        low_power_flag
);
  // ----------
  // dwell counters
  // ----------
  localparam int lp_lim   = (sleep_ms_3 + jitter_high_ms) * ms_cycles + 4;
  localparam int wake_lim = wake_ms_3 * ms_cycles + 4;
  int lp_cnt;
  int wake_cnt;
  int next_lp_cnt;
  int next_wake_cnt;
  always_comb begin
    next_lp_cnt   = low_power_flag ? lp_cnt + 1 : 0;
    next_wake_cnt = burst_active ? wake_cnt + 1 : 0;
  end
  always_ff @(posedge clk) begin
    lp_cnt   <= srst ? 0 : next_lp_cnt;
    wake_cnt <= srst ? 0 : next_wake_cnt;
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_energy_held; energy_detect [*5]; endsequence
  sequence s_wake_end; $fell(burst_active); endsequence
  property p_reset_low; $fell(srst) |-> low_power_flag && !burst_active && !blocks_on; endproperty
  a_reset_low: assert property (p_reset_low) else $error("not low power after reset");
  property p_ack_time; s_req |=> wb_ack_o; endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_one_state;
    !(low_power_flag && (burst_active || blocks_on)) && !(burst_active && blocks_on);
  endproperty
  a_one_state: assert property (p_one_state) else $error("two states at once");
  property p_pd; manual_power_down |-> !blocks_on; endproperty
  a_pd: assert property (p_pd) else $error("blocks on in power-down");
  property p_energy; s_energy_held |-> !low_power_flag && !burst_active; endproperty
  a_energy: assert property (p_energy) else $error("energy ignored");
  property p_wake_len; burst_active |-> wake_cnt <= wake_lim; endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake too long");
  property p_low_len; low_power_flag |-> lp_cnt <= lp_lim; endproperty
  a_low_len: assert property (p_low_len) else $error("sleep too long");
  property p_wake_ret; s_wake_end |-> low_power_flag || blocks_on || manual_power_down; endproperty
  a_wake_ret: assert property (p_wake_ret) else $error("wake exit to no state");
endmodule : power_saver_sva

bind phy_link_power_saver power_saver_sva #(
  .ms_cycles(ms_cycles), .wake_ms_3(wake_ms_3), .sleep_ms_3(sleep_ms_3)
) power_saver_sva_i (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .energy_detect(energy_detect),
  .blocks_on(blocks_on), .burst_active(burst_active),
  .manual_power_down(manual_power_down), .low_power_flag(low_power_flag)
);

// >>> sim/link_partner.sv
// link partner model: energy and link on the cable
// assumes mode from the bench: 0 absent, 1 asleep until a burst, 2 active
`timescale 1ns/10ps
module link_partner #(
  parameter int link_delay = 8
)(
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic       burst_active,
  output logic            energy_detect,
  output logic            link_up
);
  logic awake = 1'b0;
  int   cnt   = 0;
  always @(posedge clk) begin
    awake <= (mode == 2'h2) || (mode == 2'h1 && (awake || burst_active));
    cnt   <= awake ? ((cnt < link_delay) ? cnt + 1 : cnt) : 0;
  end
  assign energy_detect = awake;
  assign link_up       = awake && cnt == link_delay;
endmodule : link_partner

// >>> sim/tb.sv
// tb: wishbone driven tests of the link power saver
// assumes short timing params and the partner model beside the port
`timescale 1ns/10ps
module tb;
  import power_saver_pkg::*;
  localparam int msc = 2;
  // wake and link time-out maps stay at their defaults
  localparam int wake_def[4] = '{160, 400, 800, 1600};
  localparam int lt0 = 1000;
  localparam int lt1 = 2000;
  logic        clk      = 1'b0;
  logic        srst     = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [1:0]  mode     = 2'h0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, energy_detect, link_up, blocks_on, burst_active;
  logic        burst_pair_b, manual_power_down, low_power_flag;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n, len, tog, exp_len;

  always #2.5 clk = ~clk;

  phy_link_power_saver #(
    .sleep_ms_0(100), .sleep_ms_1(200), .sleep_ms_2(300), .sleep_ms_3(400),
    .ms_cycles(msc)
  ) phy_link_power_saver_i (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .energy_detect(energy_detect),
    .link_up(link_up), .blocks_on(blocks_on), .burst_active(burst_active),
    .burst_pair_b(burst_pair_b), .manual_power_down(manual_power_down),
    .low_power_flag(low_power_flag)
  );
  link_partner link_partner_i (
    .clk(clk), .mode(mode), .burst_active(burst_active),
    .energy_detect(energy_detect), .link_up(link_up)
  );
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'b11, we, a, 4'h3, 16'h0000, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 16'h0000, rd);
    chk(rd === e, m);
  endtask : rchk
  function automatic logic sig(input int w);
    case (w)
      0: return burst_active;
      1: return !burst_active;
      2: return low_power_flag;
      default: return blocks_on;
    endcase
  endfunction : sig
  task automatic wait_for(input int w, input int lim, output int c);
    c = 0;
    while (sig(w) !== 1'b1 && c < lim) begin
      @(posedge clk);
      c++;
    end
    chk(c < lim, "state not reached");
  endtask : wait_for
  task automatic wake_run(output int l, output int t);
    logic prev;
    l = 0;
    t = 0;
    prev = burst_pair_b;
    while (burst_active === 1'b1 && l < 5000) begin
      @(posedge clk);
      l++;
      if (burst_active === 1'b1 && burst_pair_b !== prev) t++;
      prev = burst_pair_b;
    end
  endtask : wake_run
  // ----------
  // tests
  // ----------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rchk(control_addr, 32'h0000_1000, "control reset");
    rchk(saver_addr, 32'h0000_0000, "saver reset");
    rchk(timer_addr, 32'h0000_2000, "timer reset");
    rchk(8'h10, 32'h0000_0000, "unmapped read");
    bus(1'b1, saver_addr, 16'h0040, rd);
    wait_for(2, lt0 * msc + 20, n);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, timer_addr, 16'(s * 32'h2800), rd);
      wait_for(2, 4000, n);
      wait_for(0, 1000, n);
      wake_run(len, tog);
      exp_len = burst_count * (wake_def[s] / burst_count) * msc;
      chk(len >= exp_len - 2 && len <= exp_len + 2, "wake");
      chk(tog == burst_count - 1, "pair toggles");
      wait_for(0, 1000, n);
      chk(n >= (20 + 100 * s) * msc - 2 && n <= (160 + 100 * s) * msc + 4, "sleep");
    end
    rchk(status_addr, 32'h0000_0002, "status wake");
    mode <= 2'h1;
    wait_for(3, 1000, n);
    repeat (20) @(posedge clk);
    rchk(status_addr, 32'h0000_001C, "status normal");
    bus(1'b1, control_addr, 16'h1800, rd);
    repeat (2) @(posedge clk);
    chk(manual_power_down === 1'b1 && blocks_on === 1'b0, "power down");
    bus(1'b1, control_addr, 16'h1000, rd);
    bus(1'b1, saver_addr, 16'h0044, rd);
    mode <= 2'h0;
    wait_for(2, lt1 * msc + 20, n);
    chk(n >= lt1 * msc && n <= lt1 * msc + 10, "link time-out");
    mode <= 2'h2;
    wait_for(3, 1000, n);
    bus(1'b1, control_addr, 16'h0000, rd);
    mode <= 2'h0;
    repeat ((lt1 + 50) * msc) @(posedge clk);
    chk(low_power_flag === 1'b0 && blocks_on === 1'b1, "stays up");
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    bus(1'b1, saver_addr, 16'h0040, rd);
    wait_for(2, lt0 * msc + 20, n);
    bus(1'b1, control_addr, 16'h0000, rd);
    wait_for(0, 1000, n);
    mode <= 2'h2;
    wait_for(3, 1000, n);
    mode <= 2'h0;
    repeat ((lt0 + 50) * msc) @(posedge clk);
    chk(low_power_flag === 1'b0 && blocks_on === 1'b1, "forced stays up");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : tb
